/* rtl/aspt_dev.sv */
`timescale 1ns/1ps
`default_nettype none
module aspt_dev (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Serial link
  aspt_link_if.devEnd link,
  // Register access
  input wire logic ctrlWr,
  input wire logic [7:0] ctrlWrData,
  input wire logic dataWr,
  input wire logic [7:0] dataWrData,
  output logic [7:0] ctrlRdData,
  output logic [7:0] dataRdData,
  output logic irq,
  // Baud timer setup and clock inputs
  input wire logic timerRun,
  input wire aspt_pkg::aspt_clksel_e clkSel,
  input wire logic [7:0] reloadByte,
  input wire logic extOscIn,
  input wire logic baudTimerExtInput
);
  import aspt_pkg::*;

  typedef struct packed {
    logic [2:0] rxSync;
    logic rxLevel;
    logic [2:0] t1Sync;
    logic t1Level;
    logic [2:0] oscSync;
    logic oscLevel;
    logic [5:0] presc;
    logic [2:0] oscDiv;
    logic [7:0] txTimer;
    logic txPhase;
    logic [7:0] rxTimer;
    logic rxPhase;
    logic frame9;
    logic mpf;
    logic rxEn;
    logic ninthTx;
    logic ninthRx;
    logic txDone;
    logic rxDone;
    logic [7:0] rxBuf;
    logic [10:0] txShift;
    logic [3:0] txLeft;
    logic outPin;
    logic rxBusy;
    logic [3:0] rxCnt;
    logic [8:0] rxShift;
    logic irq;
  } aspt_dev_s;

  localparam aspt_dev_s DEV_RESET = '{
    rxSync: 3'h7, rxLevel: 1'b1, t1Sync: 3'h7, t1Level: 1'b1,
    outPin: 1'b1, default: '0};

  aspt_dev_s s_reg;
  aspt_dev_s s_next;
  logic [5:0] sysTerm;
  logic sysTick;
  logic oscTick;
  logic t1Fall;
  logic tick;
  logic [8:0] txStep;
  logic [8:0] rxStep;
  logic txOvf;
  logic rxOvf;
  logic txBitTick;
  logic startDet;
  logic rxSample;
  logic [3:0] frameLen;
  logic [7:0] rxByte;
  logic rxNinth;
  logic rxCheck;

  // One step of an 8-bit auto-reload counter: {overflow, next count}
  function automatic logic [8:0] timerStep(input logic [7:0] cnt, input logic [7:0] rld);
    return (cnt == TIMER_TOP) ? {1'b1, rld} : {1'b0, cnt + 8'h01};
  endfunction : timerStep

  //////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_next = s_reg;
    frameLen = asptFrameLen(s_reg.frame9);
    // Pin synchronisers; a level counts once stages two and three agree
    s_next.rxSync = {s_reg.rxSync[1:0], link.serialInPin};
    s_next.t1Sync = {s_reg.t1Sync[1:0], baudTimerExtInput};
    s_next.oscSync = {s_reg.oscSync[1:0], extOscIn};
    if (s_reg.rxSync[1] == s_reg.rxSync[2]) begin
      s_next.rxLevel = s_reg.rxSync[2];
    end
    if (s_reg.t1Sync[1] == s_reg.t1Sync[2]) begin
      s_next.t1Level = s_reg.t1Sync[2];
    end
    if (s_reg.oscSync[1] == s_reg.oscSync[2]) begin
      s_next.oscLevel = s_reg.oscSync[2];
    end

    // Baud timer clock source
    unique case (clkSel)
      CLK_DIV12: sysTerm = DIV12_TERM;
      CLK_DIV48: sysTerm = DIV48_TERM;
      default: sysTerm = DIV4_TERM;
    endcase
    sysTick = (s_reg.presc >= sysTerm);
    s_next.presc = sysTick ? 6'h00 : s_reg.presc + 6'h01;
    oscTick = 1'b0;
    if (s_next.oscLevel && !s_reg.oscLevel) begin
      s_next.oscDiv = s_reg.oscDiv + 3'h1;
      oscTick = (s_reg.oscDiv == EXTOSC_TERM);
    end
    t1Fall = s_reg.t1Level && !s_next.t1Level;
    tick = (clkSel == CLK_EXTOSC) ? oscTick : (clkSel == CLK_EXTIN) ? t1Fall : sysTick;

    // Transmit timer; every second overflow is a bit time
    txStep = timerStep(s_reg.txTimer, reloadByte);
    txOvf = timerRun && tick && txStep[8];
    if (timerRun && tick) begin
      s_next.txTimer = txStep[7:0];
    end
    if (txOvf) begin
      s_next.txPhase = ~s_reg.txPhase;
    end
    txBitTick = txOvf && s_reg.txPhase;

    // Hidden receive timer, reloaded on a start edge
    rxStep = timerStep(s_reg.rxTimer, reloadByte);
    rxOvf = timerRun && tick && rxStep[8];
    startDet = s_reg.rxEn && !s_reg.rxBusy && s_reg.rxLevel && !s_next.rxLevel;
    if (startDet) begin
      s_next.rxTimer = reloadByte;
      s_next.rxPhase = 1'b0;
      s_next.rxBusy = 1'b1;
      s_next.rxCnt = 4'h0;
    end else begin
      if (timerRun && tick) begin
        s_next.rxTimer = rxStep[7:0];
      end
      if (rxOvf) begin
        s_next.rxPhase = ~s_reg.rxPhase;
      end
    end
    // First overflow after reload is half a bit: mid-bit sampling
    rxSample = rxOvf && !s_reg.rxPhase && s_reg.rxBusy;

    // Software control write; hardware sets below win over clears
    if (ctrlWr) begin
      s_next.frame9 = ctrlWrData[CTRL_MODE_BIT];
      s_next.mpf = ctrlWrData[CTRL_MPF_BIT];
      s_next.rxEn = ctrlWrData[CTRL_RXEN_BIT];
      s_next.ninthTx = ctrlWrData[CTRL_TX9_BIT];
      s_next.ninthRx = ctrlWrData[CTRL_RX9_BIT];
      s_next.txDone = ctrlWrData[CTRL_TXDONE_BIT];
      s_next.rxDone = ctrlWrData[CTRL_RXDONE_BIT];
    end

    // Transmitter: {stop, ninth, data, start}, shifted out LSB first
    if (dataWr && s_reg.txLeft == 4'h0) begin
      s_next.txShift = {1'b1, s_reg.frame9 ? s_reg.ninthTx : 1'b1, dataWrData, 1'b0};
      s_next.txLeft = frameLen + 4'h1;
    end else if (txBitTick && s_reg.txLeft != 4'h0) begin
      if (s_reg.txLeft != 4'h1) begin
        s_next.outPin = s_reg.txShift[0];
        s_next.txShift = {1'b1, s_reg.txShift[10:1]};
      end
      if (s_reg.txLeft == 4'h2) begin
        s_next.txDone = 1'b1;
      end
      s_next.txLeft = s_reg.txLeft - 4'h1;
    end

    // Receiver: start, data into top of shifter, optional ninth, stop
    rxByte = s_reg.frame9 ? s_reg.rxShift[7:0] : s_reg.rxShift[8:1];
    rxNinth = s_reg.frame9 ? s_reg.rxShift[8] : s_reg.rxLevel;
    rxCheck = s_reg.frame9 ? s_reg.rxShift[8] : s_reg.rxLevel;
    if (rxSample) begin
      s_next.rxCnt = s_reg.rxCnt + 4'h1;
      if (s_reg.rxCnt == 4'h0) begin
        if (s_reg.rxLevel) begin
          s_next.rxBusy = 1'b0;
        end
      end else if (s_reg.rxCnt != frameLen - 4'h1) begin
        s_next.rxShift = {s_reg.rxLevel, s_reg.rxShift[8:1]};
      end else begin
        s_next.rxBusy = 1'b0;
        // Overrun or filtered frame: buffer and flag left alone
        if (!s_reg.rxDone && (!s_reg.mpf || rxCheck)) begin
          s_next.rxBuf = rxByte;
          s_next.ninthRx = rxNinth;
          s_next.rxDone = 1'b1;
        end
      end
    end

    s_next.irq = s_next.txDone || s_next.rxDone;
  end

  //////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_reg <= DEV_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs straight from state
  assign link.serialOutPin = s_reg.outPin;
  assign ctrlRdData = {s_reg.frame9, CTRL_RESET[CTRL_SPARE_BIT], s_reg.mpf, s_reg.rxEn,
                       s_reg.ninthTx, s_reg.ninthRx, s_reg.txDone, s_reg.rxDone};
  assign dataRdData = s_reg.rxBuf;
  assign irq = s_reg.irq;

endmodule : aspt_dev
`default_nettype wire

/* rtl/aspt_pkg.sv */
`default_nettype none
package aspt_pkg;

  // Control register bit positions
  localparam int CTRL_MODE_BIT = 7;
  localparam int CTRL_SPARE_BIT = 6;
  localparam int CTRL_MPF_BIT = 5;
  localparam int CTRL_RXEN_BIT = 4;
  localparam int CTRL_TX9_BIT = 3;
  localparam int CTRL_RX9_BIT = 2;
  localparam int CTRL_TXDONE_BIT = 1;
  localparam int CTRL_RXDONE_BIT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h40;

  // Frame lengths in bit times, start and stop included
  localparam logic [3:0] FRAME8_LEN = 4'hA;
  localparam logic [3:0] FRAME9_LEN = 4'hB;

  // Baud timer clock dividers, as terminal counts
  localparam logic [5:0] DIV4_TERM = 6'h03;
  localparam logic [5:0] DIV12_TERM = 6'h0B;
  localparam logic [5:0] DIV48_TERM = 6'h2F;
  localparam logic [2:0] EXTOSC_TERM = 3'h7;
  localparam logic [7:0] TIMER_TOP = 8'hFF;

  // Baud timer clock source
  typedef enum logic [2:0] {
    CLK_DIV4,
    CLK_DIV12,
    CLK_DIV48,
    CLK_EXTOSC,
    CLK_EXTIN
  } aspt_clksel_e;

  // Bit times per frame for the selected mode
  function automatic logic [3:0] asptFrameLen(input logic frame9);
    return frame9 ? FRAME9_LEN : FRAME8_LEN;
  endfunction : asptFrameLen

endpackage : aspt_pkg
`default_nettype wire

/* rtl/aspt_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface aspt_link_if;
  logic serialOutPin;
  logic serialInPin;

  // Device end drives its transmit line, the remote end the other one
  modport devEnd (output serialOutPin, input serialInPin);
  modport hostEnd (input serialOutPin, output serialInPin);
endinterface : aspt_link_if
`default_nettype wire

/* rtl/aspt_host.sv */
`timescale 1ns/1ps
`default_nettype none
module aspt_host (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Serial link
  aspt_link_if.hostEnd link,
  // Line setup
  input wire logic frame9,
  input wire logic [15:0] bitPeriod,
  // Words to send
  input wire logic txValid,
  input wire logic [8:0] txData,
  output logic txReady,
  // Words received
  output logic rxValid,
  output logic [8:0] rxData,
  output logic rxStopBad
);
  import aspt_pkg::*;

  typedef struct packed {
    logic [2:0] rxSync;
    logic rxLevel;
    logic [1:0][8:0] fifoMem;
    logic wrPtr;
    logic rdPtr;
    logic [1:0] fill;
    logic readyOut;
    logic txBusy;
    logic [15:0] txCnt;
    logic [9:0] txShift;
    logic [3:0] txLeft;
    logic outPin;
    logic rxBusy;
    logic [15:0] rxCnt;
    logic [3:0] rxIdx;
    logic [8:0] rxShift;
    logic rxValid;
    logic [8:0] rxData;
    logic rxStopBad;
  } aspt_host_s;

  localparam aspt_host_s HOST_RESET = '{
    rxSync: 3'h7, rxLevel: 1'b1, readyOut: 1'b1, outPin: 1'b1, default: '0};

  aspt_host_s s_reg;
  aspt_host_s s_next;
  logic [3:0] frameLen;
  logic push;
  logic pop;
  logic [8:0] head;

  //////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_next = s_reg;
    frameLen = asptFrameLen(frame9);
    s_next.rxValid = 1'b0;
    s_next.rxSync = {s_reg.rxSync[1:0], link.serialOutPin};
    if (s_reg.rxSync[1] == s_reg.rxSync[2]) begin
      s_next.rxLevel = s_reg.rxSync[2];
    end

    // Two-entry buffer; the shifter drains it only when idle
    head = s_reg.fifoMem[s_reg.rdPtr];
    push = txValid && s_reg.readyOut;
    pop = !s_reg.txBusy && s_reg.fill != 2'h0;
    if (push) begin
      s_next.fifoMem[s_reg.wrPtr] = txData;
      s_next.wrPtr = ~s_reg.wrPtr;
    end
    if (pop) begin
      s_next.rdPtr = ~s_reg.rdPtr;
    end
    s_next.fill = s_reg.fill + {1'b0, push} - {1'b0, pop};
    s_next.readyOut = (s_next.fill != 2'h2);

    // Transmitter: start bit at once, then the rest per bit period
    if (pop) begin
      s_next.txBusy = 1'b1;
      s_next.outPin = 1'b0;
      s_next.txShift = {1'b1, frame9 ? head[8] : 1'b1, head[7:0]};
      s_next.txLeft = frameLen - 4'h1;
      s_next.txCnt = bitPeriod - 16'h0001;
    end else if (s_reg.txBusy) begin
      if (s_reg.txCnt != 16'h0000) begin
        s_next.txCnt = s_reg.txCnt - 16'h0001;
      end else if (s_reg.txLeft != 4'h0) begin
        s_next.outPin = s_reg.txShift[0];
        s_next.txShift = {1'b1, s_reg.txShift[9:1]};
        s_next.txLeft = s_reg.txLeft - 4'h1;
        s_next.txCnt = bitPeriod - 16'h0001;
      end else begin
        s_next.txBusy = 1'b0;
      end
    end

    // Receiver: start edge, then samples at mid-bit
    if (!s_reg.rxBusy) begin
      if (s_reg.rxLevel && !s_next.rxLevel) begin
        s_next.rxBusy = 1'b1;
        s_next.rxIdx = 4'h0;
        s_next.rxCnt = {1'b0, bitPeriod[15:1]};
      end
    end else if (s_reg.rxCnt != 16'h0000) begin
      s_next.rxCnt = s_reg.rxCnt - 16'h0001;
    end else begin
      s_next.rxCnt = bitPeriod - 16'h0001;
      s_next.rxIdx = s_reg.rxIdx + 4'h1;
      if (s_reg.rxIdx == 4'h0) begin
        s_next.rxBusy = !s_reg.rxLevel;
      end else if (s_reg.rxIdx != frameLen - 4'h1) begin
        s_next.rxShift = {s_reg.rxLevel, s_reg.rxShift[8:1]};
      end else begin
        s_next.rxBusy = 1'b0;
        s_next.rxValid = 1'b1;
        s_next.rxData = frame9 ? s_reg.rxShift : {1'b0, s_reg.rxShift[8:1]};
        s_next.rxStopBad = !s_reg.rxLevel;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_reg <= HOST_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs straight from state
  assign link.serialInPin = s_reg.outPin;
  assign txReady = s_reg.readyOut;
  assign rxValid = s_reg.rxValid;
  assign rxData = s_reg.rxData;
  assign rxStopBad = s_reg.rxStopBad;

endmodule : aspt_host
`default_nettype wire

/* dv/aspt_link_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module aspt_link_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Link lines
  input wire logic serialOutPin,
  input wire logic serialInPin
);
  localparam logic [11:0] BIT_LEN = 12'h060;
  localparam logic [11:0] FRAME_MAX = 12'h3C0;
  logic outPrev_reg, inPrev_reg;
  logic [11:0] outRun_reg, inRun_reg;
  ////////////////////////////////////////
  // Length of the present level on each line, saturating
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      outPrev_reg <= 1'b1;
      inPrev_reg <= 1'b1;
      outRun_reg <= 12'hFFF;
      inRun_reg <= 12'hFFF;
    end else begin
      outPrev_reg <= serialOutPin;
      inPrev_reg <= serialInPin;
      outRun_reg <= (serialOutPin != outPrev_reg) ? 12'h001 :
        outRun_reg + {11'h000, outRun_reg != 12'hFFF};
      inRun_reg <= (serialInPin != inPrev_reg) ? 12'h001 :
        inRun_reg + {11'h000, inRun_reg != 12'hFFF};
    end
  end
  ////////////////////////////////////////
  // Line checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  out_idle_reset_a: assert property ($rose(nrst) |-> serialOutPin)
    else $error("transmit line not idle after reset");
  in_idle_reset_a: assert property ($rose(nrst) |-> serialInPin)
    else $error("receive line not idle after reset");
  out_min_bit_a: assert property (serialOutPin != outPrev_reg |-> outRun_reg >= BIT_LEN)
    else $error("transmit level shorter than one bit");
  in_min_bit_a: assert property (serialInPin != inPrev_reg |-> inRun_reg >= BIT_LEN)
    else $error("receive level shorter than one bit");
  out_low_whole_a: assert property (serialOutPin && !outPrev_reg |->
    (outRun_reg % BIT_LEN) == 12'h000) else $error("transmit low run not whole bits");
  in_low_whole_a: assert property (serialInPin && !inPrev_reg |->
    (inRun_reg % BIT_LEN) == 12'h000) else $error("receive low run not whole bits");
  out_frame_len_a: assert property (!serialOutPin && !outPrev_reg |-> outRun_reg < FRAME_MAX)
    else $error("transmit low run longer than a frame");
  in_frame_len_a: assert property (!serialInPin && !inPrev_reg |-> inRun_reg < FRAME_MAX)
    else $error("receive low run longer than a frame");
endmodule : aspt_link_chk
`default_nettype wire

/* dv/async_serial_port_with_timer_baud_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module async_serial_port_with_timer_baud_tb_top;
  import aspt_pkg::*;
  // One ordinary case: timer setup, mode and words both ways
  typedef struct packed {
    aspt_clksel_e sel;
    logic [7:0] rel;
    logic f9;
    logic tx9;
    logic filt;
    logic [7:0] devByte;
    logic [8:0] hostWord;
  } aspt_row_s;
  logic clk_sys, nrst, ctrlWr, dataWr, timerRun, extOscIn, baudTimerExtInput;
  logic frame9, txValid, irq, txReady, rxValid, rxStopBad, lastStop, expNinth, acc;
  logic [7:0] ctrlWrData, dataWrData, reloadByte, ctrlRdData, dataRdData, expData, expCtrl;
  logic [8:0] txData, rxData, lastRx;
  logic [15:0] bitPeriod;
  aspt_clksel_e clkSel;
  int errors, testsRun, rxCount, n0, pinDiv;
  aspt_row_s rows [5];
  aspt_row_s r;
  ////////////////////////////////////////
  // Both ends joined by the link, checker beside it
  aspt_link_if link ();
  aspt_dev i_aspt_dev (.clk_sys(clk_sys), .nrst(nrst), .link(link.devEnd), .ctrlWr(ctrlWr),
    .ctrlWrData(ctrlWrData), .dataWr(dataWr), .dataWrData(dataWrData),
    .ctrlRdData(ctrlRdData), .dataRdData(dataRdData), .irq(irq), .timerRun(timerRun),
    .clkSel(clkSel), .reloadByte(reloadByte), .extOscIn(extOscIn),
    .baudTimerExtInput(baudTimerExtInput));
  aspt_host i_aspt_host (.clk_sys(clk_sys), .nrst(nrst), .link(link.hostEnd),
    .frame9(frame9), .bitPeriod(bitPeriod), .txValid(txValid), .txData(txData),
    .txReady(txReady), .rxValid(rxValid), .rxData(rxData), .rxStopBad(rxStopBad));
  aspt_link_chk i_aspt_link_chk (.clk_sys(clk_sys), .nrst(nrst),
    .serialOutPin(link.serialOutPin), .serialInPin(link.serialInPin));
  ////////////////////////////////////////
  // Clock, timer source pins and receive monitor
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pinDiv <= 0;
      extOscIn <= 1'b0;
      baudTimerExtInput <= 1'b0;
      rxCount <= 0;
      lastRx <= 9'h000;
      lastStop <= 1'b0;
    end else begin
      // Pins hold three cycles so the three-flop filter lets them through
      pinDiv <= (pinDiv == 2) ? 0 : pinDiv + 1;
      if (pinDiv == 2) begin
        extOscIn <= ~extOscIn;
        baudTimerExtInput <= ~baudTimerExtInput;
      end
      if (rxValid) begin
        rxCount <= rxCount + 1;
        lastRx <= rxData;
        lastStop <= rxStopBad;
      end
    end
  end
  ////////////////////////////////////////
  // Helpers
  task chk(input logic [8:0] got, input logic [8:0] exp);
    testsRun++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task regW(input logic sel, input logic [7:0] v);
    @(posedge clk_sys);
    ctrlWr <= !sel;
    dataWr <= sel;
    ctrlWrData <= v;
    dataWrData <= v;
    @(posedge clk_sys);
    ctrlWr <= 1'b0;
    dataWr <= 1'b0;
  endtask : regW
  task push(input logic [8:0] w);
    @(posedge clk_sys);
    txValid <= 1'b1;
    txData <= w;
    @(negedge clk_sys);
    while (txReady !== 1'b1) @(negedge clk_sys);
    @(posedge clk_sys);
    txValid <= 1'b0;
  endtask : push
  task tally_and_finish();
    if (errors == 0 && testsRun > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (40000) @(posedge clk_sys);
    errors++;
    tally_and_finish();
  end
  ////////////////////////////////////////
  // Main sequence; every timer setup gives a 96 cycle bit
  initial begin
    {nrst, ctrlWr, dataWr, ctrlWrData, dataWrData} = '0;
    {frame9, txValid, txData, expData} = '0;
    errors = 0;
    testsRun = 0;
    timerRun = 1'b1;
    clkSel = CLK_DIV4;
    reloadByte = 8'hF4;
    bitPeriod = 16'h0060;
    rows = '{'{CLK_DIV4, 8'hF4, 1'b0, 1'b1, 1'b0, 8'hA5, 9'h13C},
      '{CLK_DIV12, 8'hFC, 1'b1, 1'b1, 1'b0, 8'h3C, 9'h05C},
      '{CLK_DIV48, 8'hFF, 1'b1, 1'b0, 1'b1, 8'hC2, 9'h1E7},
      '{CLK_EXTOSC, 8'hFF, 1'b0, 1'b0, 1'b1, 8'h69, 9'h181},
      '{CLK_EXTIN, 8'hF8, 1'b1, 1'b1, 1'b1, 8'h0F, 9'h03C}};
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      r = rows[i];
      acc = !r.filt || (r.f9 ? r.hostWord[8] : 1'b1);
      @(posedge clk_sys);
      clkSel <= r.sel;
      reloadByte <= r.rel;
      frame9 <= r.f9;
      regW(1'b0, {r.f9, 1'b0, r.filt, 1'b1, r.tx9, 3'h0});
      expNinth = 1'b0;
      n0 = rxCount;
      regW(1'b1, r.devByte);
      push(r.hostWord);
      for (int k = 0; k < 3000 && rxCount == n0; k++) @(posedge clk_sys);
      for (int k = 0; k < 1500 && ctrlRdData[0] !== 1'b1; k++) @(posedge clk_sys);
      // The device is still in its stop bit; a write now would be dropped
      repeat (150) @(posedge clk_sys);
      @(negedge clk_sys);
      if (acc) begin
        expData = r.hostWord[7:0];
        expNinth = r.f9 ? r.hostWord[8] : 1'b1;
      end
      expCtrl = {r.f9, 1'b1, r.filt, 1'b1, r.tx9, expNinth, 1'b1, acc};
      chk(lastRx, {r.f9 & r.tx9, r.devByte});
      chk({8'h00, lastStop}, 9'h000);
      chk({1'b0, dataRdData}, {1'b0, expData});
      chk({irq, ctrlRdData}, {1'b1, expCtrl});
    end
    // Second write during a frame is dropped, receiver off
    @(posedge clk_sys);
    clkSel <= CLK_DIV4;
    reloadByte <= 8'hF4;
    frame9 <= 1'b0;
    regW(1'b0, 8'h00);
    n0 = rxCount;
    regW(1'b1, 8'h5A);
    repeat (5) @(posedge clk_sys);
    regW(1'b1, 8'hC3);
    push(9'h0F0);
    for (int k = 0; k < 3000 && rxCount == n0; k++) @(posedge clk_sys);
    repeat (1200) @(posedge clk_sys);
    chk(9'(rxCount - n0), 9'h001);
    chk(lastRx, 9'h05A);
    chk({dataRdData, 1'b0}, {expData, 1'b0});
    chk({1'b0, ctrlRdData}, 9'h042);
    regW(1'b0, 8'h10);
    repeat (2) @(posedge clk_sys);
    chk({irq, ctrlRdData}, 9'h050);
    // Three words back to back: buffer fills, receiver overruns
    push(9'h011);
    push(9'h022);
    push(9'h033);
    @(negedge clk_sys);
    chk({8'h00, txReady}, 9'h000);
    repeat (3500) @(posedge clk_sys);
    chk({1'b0, dataRdData}, 9'h011);
    chk({txReady, ctrlRdData}, 9'h155);
    // Reset in mid-run
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk({1'b0, ctrlRdData}, 9'h040);
    chk({irq, dataRdData}, 9'h000);
    chk({8'h00, txReady}, 9'h001);
    nrst <= 1'b1;
    // Two edges after release: lines idle, control at its reset value
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk({irq, ctrlRdData}, 9'h040);
    chk({txReady, link.serialOutPin, link.serialInPin, 6'h00}, 9'h1C0);
    tally_and_finish();
  end
endmodule : async_serial_port_with_timer_baud_tb_top
`default_nettype wire
